// File: design/stack_pkg.sv
// Shared constants and types for the stack pointer and limit checker.
// Assumes a 16-bit byte-addressed data space with word-aligned stacks.
package stack_pkg;

  localparam int          ADDR_W      = 16;
  localparam int          BYTE_W      = 8;
  localparam int          PC_HI_W     = 8;
  // Addresses below this floor belong to the special register space.
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  // One 16-bit word is two byte addresses.
  localparam logic [15:0] WORD_STEP   = 16'h0002;
  // Pointer value after reset; chosen to sit on the floor.
  localparam logic [15:0] SP_RESET    = 16'h0800;
  localparam logic [15:0] ZERO_WORD   = 16'h0000;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam int          ALIGN_BIT   = 0;

  // What a push places on the stack.
  typedef enum logic [1:0] {
    PUSH_DATA = 2'b00,
    PUSH_CALL = 2'b01,
    PUSH_EXC  = 2'b10
  } push_kind_t;

endpackage

// File: design/limit_if.sv
// Carrier between the stack pointer logic and its limit comparator.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ns
interface limit_if;
  logic [15:0] effective_addr; // Address formed through the stack pointer.
  logic [15:0] limit;          // Current stack limit, bit 0 clear.
  logic        over;           // Address lies above the limit.
  logic        under;          // Address lies below the floor.

  modport cmp (
    input  effective_addr,
    input  limit,
    output over,
    output under
  );
  modport ctl (
    output effective_addr,
    output limit,
    input  over,
    input  under
  );
endinterface // limit_if

// File: design/limit_compare.sv
// Combinational comparator of a stack effective address with the limits.
// Assumes the caller forms the address and holds the limit register.
`timescale 1ns/1ns
module limit_compare (
  limit_if.cmp bus // Address in, over and under flags out.
);
  import stack_pkg::*;

  // Both bounds are checked on every address so a single trap covers both.
  always_comb begin
    bus.over  = bus.effective_addr > bus.limit;
    bus.under = bus.effective_addr < STACK_FLOOR;
  end

endmodule // limit_compare

// File: design/stack_pointer_limit_checker.sv
// Stack pointer register, push and pop sequencing and stack error trap.
// Assumes the core issues at most one stack request per cycle on its clock.
`timescale 1ns/1ns
module stack_pointer_limit_checker (
  input  wire logic                 clock_i,      // Core clock, 100 MHz.
  input  wire logic                 arst_n_i,     // Asynchronous reset.
  input  wire logic                 push_i,       // Push request pulse.
  input  wire stack_pkg::push_kind_t push_kind_i, // What is pushed.
  input  wire logic [15:0]          push_data_i,  // Data word for a push.
  input  wire logic [7:0]           pc_high_i,    // Upper counter byte.
  input  wire logic [7:0]           status_low_byte_i, // Low status byte.
  input  wire logic                 pop_i,        // Pop request pulse.
  input  wire logic                 access_i,     // Indirect access pulse.
  input  wire logic [15:0]          effective_addr_i, // Its address.
  input  wire logic                 sp_write_i,   // Direct pointer write.
  input  wire logic [15:0]          sp_data_i,    // Value for the pointer.
  input  wire logic                 limit_write_i, // Limit write pulse.
  input  wire logic [15:0]          limit_data_i, // Value for the limit.
  output logic                      mem_write_o,  // Stack write strobe.
  output logic                      mem_read_o,   // Stack read strobe.
  output logic [15:0]               mem_addr_o,   // Stack access address.
  output logic [15:0]               mem_wdata_o,  // Stack write data.
  output logic [15:0]               stack_pointer_o, // Pointer value.
  output logic [15:0]               stack_limit_o, // Limit value.
  output logic                      stack_error_o // Stack error trap pulse.
);
  import stack_pkg::*;

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [15:0] stack_pointer_reg;
  logic [15:0] stack_limit_reg;
  logic [15:0] next_pointer;
  logic [15:0] push_word;
  logic        do_push;
  logic        do_pop;
  logic        do_access;
  logic        trap;
  limit_if     cmp_bus ();

  // Reset is released through two flip-flops so removal is synchronous.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Request priority: pointer write, then push, then pop, then access.
  assign do_push   = push_i && !sp_write_i;
  assign do_pop    = pop_i && !push_i && !sp_write_i;
  assign do_access = access_i && !push_i && !pop_i && !sp_write_i;

  // Address that the current request forms through the pointer.
  always_comb begin
    next_pointer = stack_pointer_reg - WORD_STEP;
    if (do_push) begin
      cmp_bus.effective_addr = stack_pointer_reg;
    end else if (do_pop) begin
      cmp_bus.effective_addr = next_pointer;
    end else begin
      cmp_bus.effective_addr = effective_addr_i;
    end
  end
  assign cmp_bus.limit = stack_limit_reg;

  limit_compare u_cmp (
    .bus (cmp_bus)
  );

  // A push at the limit itself compares equal and passes; one beyond traps.
  assign trap = (do_push || do_pop || do_access) &&
                (cmp_bus.over || cmp_bus.under);

  // Word placed on the stack for each kind of push.
  always_comb begin
    case (push_kind_i)
      PUSH_CALL: push_word = {ZERO_BYTE, pc_high_i};
      PUSH_EXC:  push_word = {status_low_byte_i, pc_high_i};
      default:   push_word = push_data_i;
    endcase
  end

  // The limit has no reset: software must load it before the stack is used.
  // A write lands at the next edge, so an access in the same cycle still sees the old
  // limit; the core is expected not to issue one then.
  always_ff @(posedge clock_i) begin
    if (limit_write_i) begin
      stack_limit_reg <= {limit_data_i[15:1], 1'b0};
    end
  end

  // Pointer update; a trapped request leaves the pointer untouched.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stack_pointer_reg <= SP_RESET;
    end else if (!rst_n) begin
      stack_pointer_reg <= SP_RESET;
    end else if (sp_write_i) begin
      stack_pointer_reg <= {sp_data_i[15:1], 1'b0};
    end else if (do_push && !trap) begin
      stack_pointer_reg <= stack_pointer_reg + WORD_STEP;
    end else if (do_pop && !trap) begin
      stack_pointer_reg <= next_pointer;
    end
  end

  // Memory strobes: write at the old pointer, read at the new one.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_write_o <= 1'b0;
      mem_read_o  <= 1'b0;
      mem_addr_o  <= ZERO_WORD;
      mem_wdata_o <= ZERO_WORD;
    end else if (!rst_n) begin
      mem_write_o <= 1'b0;
      mem_read_o  <= 1'b0;
      mem_addr_o  <= ZERO_WORD;
      mem_wdata_o <= ZERO_WORD;
    end else begin
      mem_write_o <= do_push && !trap;
      mem_read_o  <= do_pop && !trap;
      if (do_push) begin
        mem_addr_o  <= stack_pointer_reg;
        mem_wdata_o <= push_word;
      end else if (do_pop) begin
        mem_addr_o <= next_pointer;
      end
    end
  end

  // Trap pulse and registered copies of pointer and limit.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stack_error_o   <= 1'b0;
      stack_pointer_o <= SP_RESET;
      stack_limit_o   <= ZERO_WORD;
    end else if (!rst_n) begin
      stack_error_o   <= 1'b0;
      stack_pointer_o <= SP_RESET;
      stack_limit_o   <= ZERO_WORD;
    end else begin
      stack_error_o   <= trap;
      stack_pointer_o <= stack_pointer_reg;
      stack_limit_o   <= stack_limit_reg;
    end
  end

  // Checks on the sequencing above.
  default clocking main_clk @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  sequence push_ok_s;
    do_push && !trap;
  endsequence

  sequence push_at_limit_s;
    do_push && stack_pointer_reg == stack_limit_reg &&
    stack_pointer_reg >= STACK_FLOOR;
  endsequence

  AST_PUSH_STEP: assert property (
    push_ok_s |=> stack_pointer_reg == $past(stack_pointer_reg) + WORD_STEP
  ) else $error("push did not advance the pointer by one word");

  AST_PUSH_ORDER: assert property (
    push_ok_s |=> mem_write_o && mem_addr_o == $past(stack_pointer_reg)
  ) else $error("push did not write at the old pointer");

  AST_POP_ORDER: assert property (
    do_pop && !trap |=> mem_read_o &&
      mem_addr_o == $past(stack_pointer_reg) - WORD_STEP &&
      mem_addr_o == stack_pointer_reg
  ) else $error("pop did not read at the decremented pointer");

  AST_FREE_WORD: assert property (
    push_ok_s ##1 (!sp_write_i && !push_i && pop_i && !trap) |=>
      mem_addr_o == $past(mem_addr_o)
  ) else $error("pop after push did not return the pushed word");

  AST_CALL_ZERO: assert property (
    push_ok_s and push_kind_i == PUSH_CALL |=> mem_wdata_o[15:8] == ZERO_BYTE
  ) else $error("call push left the upper byte set");

  AST_EXC_STATUS: assert property (
    push_ok_s and push_kind_i == PUSH_EXC |=>
      mem_wdata_o == {$past(status_low_byte_i), $past(pc_high_i)}
  ) else $error("exception push lost the status byte");

  AST_LIMIT_EVEN: assert property (
    limit_write_i |=> stack_limit_reg[ALIGN_BIT] == 1'b0
  ) else $error("limit bit zero is not clear");

  AST_AT_LIMIT: assert property (
    push_at_limit_s |=> !stack_error_o && mem_write_o
  ) else $error("push at the limit trapped");

  AST_BEYOND: assert property (
    push_at_limit_s ##1 (do_push && !limit_write_i) |=> stack_error_o
  ) else $error("push beyond the limit did not trap");

  AST_UNDER: assert property (
    do_pop && next_pointer < STACK_FLOOR |=>
      stack_error_o && !mem_read_o
  ) else $error("pop below the floor did not trap");

  AST_COMPARE: assert property (
    do_access && effective_addr_i > stack_limit_reg |=> stack_error_o
  ) else $error("access above the limit did not trap");

endmodule // stack_pointer_limit_checker

// File: test/stack_mem_model.sv
// Stack memory behind the core: keeps pushed words and returns popped ones.
// Assumes the block's registered strobes on the same core clock.
`timescale 1ns/1ns
module stack_mem_model (
  input  wire logic        clock_i, // Core clock.
  input  wire logic        write_i, // Stack write strobe.
  input  wire logic        read_i,  // Stack read strobe.
  input  wire logic [15:0] addr_i,  // Stack byte address.
  input  wire logic [15:0] wdata_i, // Word pushed.
  output logic      [15:0] rdata_o  // Word popped.
);
  logic [15:0] mem [0:4095];

  // A read lands one cycle after its strobe; between reads the bus toggles,
  // so a stale word reads back inverted one cycle on and returns every second cycle.
  always_ff @(posedge clock_i) begin
    if (write_i) begin
      mem[addr_i[12:1]] <= wdata_i;
    end
    if (read_i) begin
      rdata_o <= mem[addr_i[12:1]];
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule // stack_mem_model

// File: test/tb.sv
// Self-checking bench for the stack pointer and limit checker.
// Assumes the design package and a stack memory model beside the block.
`timescale 1ns/1ns
module tb;
  import stack_pkg::*;
  logic        clock_i, arst_n_i, push_i, pop_i, access_i;
  logic        sp_write_i, limit_write_i, mem_write_o, mem_read_o;
  logic        stack_error_o;
  push_kind_t  push_kind_i;
  logic [15:0] push_data_i, effective_addr_i, sp_data_i, limit_data_i;
  logic [15:0] mem_addr_o, mem_wdata_o, stack_pointer_o, stack_limit_o;
  logic [15:0] rdata;
  logic [15:0] exp_w [3];
  logic [7:0]  pc_high_i, status_low_byte_i;
  int          fail_count = 0;
  int          cmp_count = 0;

  stack_pointer_limit_checker uut (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .push_i(push_i), .push_kind_i(push_kind_i), .push_data_i(push_data_i),
    .pc_high_i(pc_high_i), .status_low_byte_i(status_low_byte_i),
    .pop_i(pop_i), .access_i(access_i), .effective_addr_i(effective_addr_i),
    .sp_write_i(sp_write_i), .sp_data_i(sp_data_i),
    .limit_write_i(limit_write_i), .limit_data_i(limit_data_i),
    .mem_write_o(mem_write_o), .mem_read_o(mem_read_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .stack_pointer_o(stack_pointer_o), .stack_limit_o(stack_limit_o),
    .stack_error_o(stack_error_o));
  stack_mem_model mem_model (.clock_i(clock_i), .write_i(mem_write_o),
    .read_i(mem_read_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .rdata_o(rdata));

  // The core clock, 10 ns period.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic chk(input string what, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One request for one cycle; returns just after the answer edge.
  task automatic req(input int op, input logic [15:0] v, input push_kind_t k);
    @(posedge clock_i);
    push_kind_i <= k;
    push_data_i <= v;
    effective_addr_i <= v;
    sp_data_i <= v;
    limit_data_i <= v;
    push_i <= (op == 0);
    pop_i <= (op == 1);
    access_i <= (op == 2);
    sp_write_i <= (op == 3);
    limit_write_i <= (op == 4);
    @(posedge clock_i);
    {push_i, pop_i, access_i, sp_write_i, limit_write_i} <= 5'b0_0000;
    #1;
  endtask

  task automatic t_stack();
    exp_w = '{16'hA5C3, 16'h005A, 16'h3C5A};
    req(4, 16'h0FFF, PUSH_DATA);
    @(posedge clock_i);
    #1;
    chk("limit", 16'h0FFE, stack_limit_o);
    @(posedge clock_i);
    for (int i = 0; i < 3; i++) begin
      req(0, 16'hA5C3, push_kind_t'(i));
      chk("wr", 16'h0001, {15'h0000, mem_write_o});
      chk("waddr", 16'h0800 + 16'(2 * i), mem_addr_o);
      chk("wdata", exp_w[i], mem_wdata_o);
    end
    @(posedge clock_i);
    #1;
    chk("sp", 16'h0806, stack_pointer_o);
    for (int i = 2; i >= 0; i--) begin
      req(1, 16'h0000, PUSH_DATA);
      chk("rd", 16'h0001, {15'h0000, mem_read_o});
      chk("raddr", 16'h0800 + 16'(2 * i), mem_addr_o);
      @(posedge clock_i);
      #1;
      chk("rdata", exp_w[i], rdata);
    end
    $display("Test push and pop finished");
  endtask

  task automatic t_bounds();
    req(3, 16'h0FFC, PUSH_DATA);
    req(0, 16'h1111, PUSH_DATA);
    req(0, 16'h2222, PUSH_DATA);
    chk("err at limit", 16'h0000, {15'h0000, stack_error_o});
    chk("waddr", 16'h0FFE, mem_addr_o);
    req(0, 16'h3333, PUSH_DATA);
    chk("err over", 16'h0001, {15'h0000, stack_error_o});
    chk("no wr", 16'h0000, {15'h0000, mem_write_o});
    @(posedge clock_i);
    #1;
    chk("sp held", 16'h1000, stack_pointer_o);
    req(3, 16'h0800, PUSH_DATA);
    req(1, 16'h0000, PUSH_DATA);
    chk("err under", 16'h0001, {15'h0000, stack_error_o});
    chk("no rd", 16'h0000, {15'h0000, mem_read_o});
    req(2, 16'h07FE, PUSH_DATA);
    chk("acc low", 16'h0001, {15'h0000, stack_error_o});
    req(2, 16'h1000, PUSH_DATA);
    chk("acc high", 16'h0001, {15'h0000, stack_error_o});
    req(2, 16'h0FFE, PUSH_DATA);
    chk("acc ok", 16'h0000, {15'h0000, stack_error_o});
    $display("Test bounds finished");
  endtask

  // Requests on consecutive edges: push at the limit, the push that traps,
  // a pop, push beating pop, and a pointer write beating a push.
  task automatic t_burst();
    req(3, 16'h0FFC, PUSH_DATA);
    @(posedge clock_i);
    push_kind_i <= push_kind_t'(2'b11);
    push_data_i <= 16'h4B4B;
    push_i <= 1'b1;
    @(posedge clock_i);
    push_data_i <= 16'h6D6D;
    #1;
    chk("kind3 wdata", 16'h4B4B, mem_wdata_o);
    @(posedge clock_i);
    #1;
    chk("b waddr", 16'h0FFE, mem_addr_o);
    chk("b err", 16'h0000, {15'h0000, stack_error_o});
    @(posedge clock_i);
    push_i <= 1'b0;
    pop_i <= 1'b1;
    #1;
    chk("b beyond", 16'h0001, {15'h0000, stack_error_o});
    chk("b no wr", 16'h0000, {15'h0000, mem_write_o});
    @(posedge clock_i);
    push_i <= 1'b1;
    #1;
    chk("b raddr", 16'h0FFE, mem_addr_o);
    chk("b rd", 16'h0001, {15'h0000, mem_read_o});
    @(posedge clock_i);
    push_i <= 1'b0;
    #1;
    chk("b rdata", 16'h6D6D, rdata);
    chk("b push wins", 16'h0000, {15'h0000, mem_read_o});
    chk("b rewrite", 16'h0FFE, mem_addr_o);
    @(posedge clock_i);
    pop_i <= 1'b0;
    sp_write_i <= 1'b1;
    sp_data_i <= 16'h0901;
    push_i <= 1'b1;
    #1;
    chk("b repop", 16'h0FFE, mem_addr_o);
    @(posedge clock_i);
    {push_i, sp_write_i} <= 2'b00;
    #1;
    chk("b sp first", 16'h0000, {15'h0000, mem_write_o});
    @(posedge clock_i);
    #1;
    chk("b sp align", 16'h0900, stack_pointer_o);
    $display("Test back to back finished");
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset, let the release settle, then the tests.
  initial begin
    {arst_n_i, push_i, pop_i, access_i, sp_write_i, limit_write_i} = 6'h00;
    push_kind_i = PUSH_DATA;
    {push_data_i, effective_addr_i, sp_data_i, limit_data_i} = 64'h0;
    pc_high_i = 8'h5A;
    status_low_byte_i = 8'h3C;
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    chk("sp reset", 16'h0800, stack_pointer_o);
    t_stack();
    t_bounds();
    t_burst();
    wrap_up();
  end

  // Tests take under a thousand cycles; this cuts a hang short.
  initial begin
    #50000;
    fail_count++;
    wrap_up();
  end
endmodule // tb
